// ---- core/cso_pkg.sv ----
// Purpose: Shared constants and types for the capacitive sense oscillator control
// Assumes: 8-bit register port, one clock at 125 MHz
// Notes:   Offsets are register indices on the plain register port

package cso_pkg;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [2:0] OFF_SENSE_CONTROL_A = 3'h0;
  localparam logic [2:0] OFF_SENSE_CONTROL_B = 3'h1;
  localparam logic [2:0] OFF_TIMER_B_CONTROL = 3'h2;
  localparam logic [2:0] OFF_TIMER_A_CONFIG  = 3'h3;
  localparam logic [2:0] OFF_TIMER_B_COUNT_L = 3'h4;
  localparam logic [2:0] OFF_TIMER_B_COUNT_H = 3'h5;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned POS_UNIT_ENABLE   = 7;
  localparam int unsigned POS_REF_MODE      = 6;
  localparam int unsigned POS_RANGE_LO      = 2;
  localparam int unsigned POS_DIR_STATUS    = 1;
  localparam int unsigned POS_TA_EXT_SEL    = 0;
  localparam int unsigned POS_TB_SRC_LO     = 6;
  localparam int unsigned POS_TB_GATE_EN    = 1;
  localparam int unsigned POS_TB_ON         = 0;
  localparam int unsigned POS_TA_CLK_SRC    = 0;

  // ------------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] RANGE_OFF_OR_NOISE = 2'h0;
  localparam logic [1:0] RANGE_LOW          = 2'h1;
  localparam logic [1:0] RANGE_MEDIUM       = 2'h2;
  localparam logic [1:0] RANGE_HIGH         = 2'h3;
  localparam logic [1:0] TB_SRC_SENSE_OSC   = 2'h3;

  localparam logic [3:0] CH_COUNT_SMALL = 4'h4;
  localparam logic [3:0] CH_COUNT_LARGE = 4'h8;
  localparam int unsigned NUM_PINS      = 8;
  localparam int unsigned TB_CNT_W      = 16;

  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [3:0] RST_CHANNEL = 4'h0;
  localparam logic [1:0] RST_RANGE   = 2'h0;

  // Oscillator operating mode
  typedef enum logic [3:0] {
    CSO_OSC_OFF   = 4'b0001,
    CSO_OSC_NOISE = 4'b0010,
    CSO_OSC_RUN   = 4'b0100,
    CSO_OSC_IDLE  = 4'b1000
  } cso_osc_mode_t;

endpackage

// ---- core/cso_timer_b.sv ----
// Purpose: Second timer counting sensing oscillator edges
// Assumes: Edge and gate inputs already synchronous to ref_clk
// Notes:   Count is cleared by a register write

`timescale 1ns/1ps

module cso_timer_b (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Control
  input  wire logic                         timer_b_on,
  input  wire logic                         timer_b_gate_enable,
  input  wire logic                         gate_level,
  input  wire logic                         count_clear,
  // Clock source
  input  wire logic                         osc_edge,
  // Result
  output logic      [cso_pkg::TB_CNT_W-1:0] count
);
  import cso_pkg::*;

  typedef struct packed {
    logic [TB_CNT_W-1:0] cnt;
  } cso_tb_state_t;

  cso_tb_state_t st_reg;
  cso_tb_state_t st_next;
  logic          run;

  always_comb begin
    st_next = st_reg;
    // Off, free running, or gated by the input
    run = timer_b_on && (!timer_b_gate_enable || gate_level);
    if (count_clear) begin
      st_next.cnt = '0;
    end else if (run && osc_edge) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;

endmodule

// ---- core/cso_ctrl.sv ----
// Purpose: Control logic of the capacitive sense oscillator unit
// Assumes: Comparator and gate inputs are asynchronous pins
// Notes:   Registers reached over a plain strobe port, read data one cycle later
//
// How it works
// - Enable bit turns the sense unit on
// - Enabled unit drives mux to selected channel
// - Four inputs small variant, eight large
// - Readable status shows oscillator source or sink
// - Reference mode picks variable or fixed thresholds
// - Range field selects off/noise, low, medium, high
// - Noise mode removes pin currents, comparator stays
// - Ext select set, source clear feeds timer A
// - Timer B source 11 counts oscillator edges
// - Timer B off, free, or gated by input
//
// Design decisions made here: the placing of the registers and the strobed register port.

`timescale 1ns/1ps

module cso_ctrl #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Register port
  input  wire logic [cso_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [cso_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [cso_pkg::DATA_W-1:0]   reg_rdata,
  // Analog oscillator front end
  input  wire logic                         osc_comparator,
  output logic                              osc_enable,
  output logic                              pin_current_enable,
  output logic                              ref_variable_select,
  output logic      [1:0]                   current_range_out,
  output logic      [cso_pkg::NUM_PINS-1:0] sense_pin_select,
  // Timers
  input  wire logic                         timer_b_gate_pin,
  output logic                              timer_a_osc_tick,
  output logic                              timer_b_osc_tick
);
  import cso_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                sense_unit_enable;
    logic                reference_mode_select;
    logic [1:0]          current_range_field;
    logic                timer_a_ext_source_select;
    logic [3:0]          sense_channel_select;
    logic [1:0]          timer_b_clock_source;
    logic                timer_b_gate_enable;
    logic                timer_b_on;
    logic                timer_a_clock_source;
    logic [1:0]          cmp_sync;
    logic                cmp_prev;
    logic [1:0]          gate_sync;
    logic                osc_direction_status;
    logic [DATA_W-1:0]   rdata;
    logic                osc_en;
    logic                drive_en;
    logic                ref_var;
    logic [1:0]          range_out;
    logic [NUM_PINS-1:0] pin_sel;
    logic                ta_tick;
    logic                tb_tick;
    logic                tb_clear;
  } cso_state_t;

  cso_state_t          st_reg;
  cso_state_t          st_next;
  cso_osc_mode_t       osc_mode;
  logic                osc_edge;
  logic                edge_allowed;
  logic [TB_CNT_W-1:0] tb_count;

  // ------------------------------------------------------------------
  // Reset value of every state field
  // ------------------------------------------------------------------
  // Register fields come up at their reset codes, pipeline stages come up idle
  localparam cso_state_t ST_RESET = '{
    sense_unit_enable:         RST_CONTROL[POS_UNIT_ENABLE],
    reference_mode_select:     RST_CONTROL[POS_REF_MODE],
    current_range_field:       RST_RANGE,
    timer_a_ext_source_select: RST_CONTROL[POS_TA_EXT_SEL],
    sense_channel_select:      RST_CHANNEL,
    timer_b_clock_source:      RST_CONTROL[POS_TB_SRC_LO +: 2],
    timer_b_gate_enable:       RST_CONTROL[POS_TB_GATE_EN],
    timer_b_on:                RST_CONTROL[POS_TB_ON],
    timer_a_clock_source:      RST_CONTROL[POS_TA_CLK_SRC],
    cmp_sync:                  2'h0,
    cmp_prev:                  1'b0,
    gate_sync:                 2'h0,
    osc_direction_status:      1'b0,
    rdata:                     '0,
    osc_en:                    1'b0,
    drive_en:                  1'b0,
    ref_var:                   RST_CONTROL[POS_REF_MODE],
    range_out:                 RST_RANGE,
    pin_sel:                   '0,
    ta_tick:                   1'b0,
    tb_tick:                   1'b0,
    tb_clear:                  1'b0
  };

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Channel code decode; unimplemented or reserved codes select nothing
  function automatic logic [NUM_PINS-1:0] ch_decode(input logic       en,
                                                    input logic [3:0] ch);
    logic [3:0]          limit;
    logic [NUM_PINS-1:0] sel;
    limit = LARGE_PACKAGE ? CH_COUNT_LARGE : CH_COUNT_SMALL;
    sel   = '0;
    if (en && (ch < limit)) begin
      sel[ch[2:0]] = 1'b1;
    end
    return sel;
  endfunction

  function automatic cso_osc_mode_t mode_decode(input logic       en,
                                                input logic       rm,
                                                input logic [1:0] rng);
    cso_osc_mode_t m;
    if (!en) begin
      m = CSO_OSC_IDLE;
    end else if (rng != RANGE_OFF_OR_NOISE) begin
      m = CSO_OSC_RUN;
    end else if (rm) begin
      m = CSO_OSC_NOISE;
    end else begin
      m = CSO_OSC_OFF;
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Pin synchronisers
    st_next.cmp_sync  = {st_reg.cmp_sync[0], osc_comparator};
    st_next.gate_sync = {st_reg.gate_sync[0], timer_b_gate_pin};
    st_next.cmp_prev  = st_reg.cmp_sync[1];

    // Register writes
    st_next.tb_clear = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFF_SENSE_CONTROL_A: begin
          st_next.sense_unit_enable         = reg_wdata[POS_UNIT_ENABLE];
          st_next.reference_mode_select     = reg_wdata[POS_REF_MODE];
          st_next.current_range_field       = reg_wdata[POS_RANGE_LO +: 2];
          st_next.timer_a_ext_source_select = reg_wdata[POS_TA_EXT_SEL];
        end
        OFF_SENSE_CONTROL_B: begin
          st_next.sense_channel_select = reg_wdata[3:0];
        end
        OFF_TIMER_B_CONTROL: begin
          st_next.timer_b_clock_source = reg_wdata[POS_TB_SRC_LO +: 2];
          st_next.timer_b_gate_enable  = reg_wdata[POS_TB_GATE_EN];
          st_next.timer_b_on           = reg_wdata[POS_TB_ON];
        end
        OFF_TIMER_A_CONFIG: begin
          st_next.timer_a_clock_source = reg_wdata[POS_TA_CLK_SRC];
        end
        OFF_TIMER_B_COUNT_L, OFF_TIMER_B_COUNT_H: begin
          st_next.tb_clear = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid only in the following cycle
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_SENSE_CONTROL_A: begin
          st_next.rdata[POS_UNIT_ENABLE]    = st_reg.sense_unit_enable;
          st_next.rdata[POS_REF_MODE]       = st_reg.reference_mode_select;
          st_next.rdata[POS_RANGE_LO +: 2]  = st_reg.current_range_field;
          st_next.rdata[POS_DIR_STATUS]     = st_reg.osc_direction_status;
          st_next.rdata[POS_TA_EXT_SEL]     = st_reg.timer_a_ext_source_select;
        end
        OFF_SENSE_CONTROL_B: begin
          st_next.rdata[3:0] = st_reg.sense_channel_select;
        end
        OFF_TIMER_B_CONTROL: begin
          st_next.rdata[POS_TB_SRC_LO +: 2] = st_reg.timer_b_clock_source;
          st_next.rdata[POS_TB_GATE_EN]     = st_reg.timer_b_gate_enable;
          st_next.rdata[POS_TB_ON]          = st_reg.timer_b_on;
        end
        OFF_TIMER_A_CONFIG: begin
          st_next.rdata[POS_TA_CLK_SRC] = st_reg.timer_a_clock_source;
        end
        OFF_TIMER_B_COUNT_L: begin
          st_next.rdata = tb_count[7:0];
        end
        OFF_TIMER_B_COUNT_H: begin
          st_next.rdata = tb_count[15:8];
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end

    // Oscillator front end controls
    st_next.pin_sel   = ch_decode(st_reg.sense_unit_enable,
                                  st_reg.sense_channel_select);
    st_next.ref_var   = st_reg.reference_mode_select;
    st_next.range_out = st_reg.current_range_field;
    case (osc_mode)
      CSO_OSC_RUN: begin
        st_next.osc_en   = 1'b1;
        st_next.drive_en = 1'b1;
      end
      CSO_OSC_NOISE: begin
        st_next.osc_en   = 1'b1;
        st_next.drive_en = 1'b0;
      end
      CSO_OSC_OFF, CSO_OSC_IDLE: begin
        st_next.osc_en   = 1'b0;
        st_next.drive_en = 1'b0;
      end
      default: begin
        st_next.osc_en   = 1'b0;
        st_next.drive_en = 1'b0;
      end
    endcase

    // Direction status: comparator high means sourcing current
    st_next.osc_direction_status = st_reg.cmp_sync[1] && st_reg.sense_unit_enable;

    // Timer clock routing
    st_next.ta_tick = edge_allowed && st_reg.timer_a_ext_source_select &&
                      !st_reg.timer_a_clock_source;
    st_next.tb_tick = edge_allowed &&
                      (st_reg.timer_b_clock_source == TB_SRC_SENSE_OSC);
  end

  // Edges of the oscillator, suppressed when disabled or switched off
  assign osc_mode     = mode_decode(st_reg.sense_unit_enable,
                                    st_reg.reference_mode_select,
                                    st_reg.current_range_field);
  assign osc_edge     = st_reg.cmp_sync[1] && !st_reg.cmp_prev;
  assign edge_allowed = osc_edge &&
                        ((osc_mode == CSO_OSC_RUN) || (osc_mode == CSO_OSC_NOISE));

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Synchronisers freeze with ce too, so a frozen block sees no pin edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // Second timer
  // ------------------------------------------------------------------
  // Clear and tick both reach the timer one cycle after their cause
  cso_timer_b u_timer_b (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .timer_b_on          (st_reg.timer_b_on),
    .timer_b_gate_enable (st_reg.timer_b_gate_enable),
    .gate_level          (st_reg.gate_sync[1]),
    .count_clear         (st_reg.tb_clear),
    .osc_edge            (st_reg.tb_tick),
    .count               (tb_count)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata           = st_reg.rdata;
  assign osc_enable          = st_reg.osc_en;
  assign pin_current_enable  = st_reg.drive_en;
  assign ref_variable_select = st_reg.ref_var;
  assign current_range_out   = st_reg.range_out;
  assign sense_pin_select    = st_reg.pin_sel;
  assign timer_a_osc_tick    = st_reg.ta_tick;
  assign timer_b_osc_tick    = st_reg.tb_tick;

endmodule

// ---- verif/cso_ctrl_chk.sv ----
// Purpose: Port checker for cso_ctrl
// Assumes: A quiet cycle follows every control write
// Notes:   Bound to every cso_ctrl
`timescale 1ns/1ps
module cso_ctrl_chk #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic                         ce,
  // Register port
  input wire logic [cso_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [cso_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [cso_pkg::DATA_W-1:0]   reg_rdata,
  // Front end and timers
  input wire logic                         osc_comparator,
  input wire logic                         osc_enable,
  input wire logic                         pin_current_enable,
  input wire logic                         ref_variable_select,
  input wire logic [1:0]                   current_range_out,
  input wire logic [cso_pkg::NUM_PINS-1:0] sense_pin_select,
  input wire logic                         timer_b_gate_pin,
  input wire logic                         timer_a_osc_tick,
  input wire logic                         timer_b_osc_tick
);
  import cso_pkg::*;
  logic [7:0] wd_q;
  logic [7:0] wd_qq;
  // Write data from two edges back
  always_ff @(posedge ref_clk) begin
    wd_q  <= reg_wdata;
    wd_qq <= wd_q;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_wr_a;
    ce && reg_wr && reg_addr == OFF_SENSE_CONTROL_A ##1 ce && !reg_wr;
  endsequence
  sequence s_osc_off;
    !osc_enable [*4];
  endsequence
  a_mode_follow:
    assert property (s_wr_a |=> ref_variable_select == wd_qq[6] &&
      current_range_out == wd_qq[3:2]) else $error("mode outputs wrong");
  a_enable_follow:
    assert property (s_wr_a |=> osc_enable == (wd_qq[7] &&
      (wd_qq[6] || wd_qq[3:2] != 2'h0))) else $error("enable wrong");
  a_current_follow:
    assert property (s_wr_a |=> pin_current_enable == (wd_qq[7] &&
      wd_qq[3:2] != 2'h0)) else $error("pin current wrong");
  a_pins_cleared:
    assert property (s_wr_a |=> wd_qq[7] || sense_pin_select == 8'h00)
      else $error("pin selected while off");
  a_pins_onehot:
    assert property ($onehot0(sense_pin_select) &&
      (LARGE_PACKAGE || sense_pin_select[7:4] == 4'h0)) else $error("pin select bad");
  a_rdata_idle:
    assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
  a_tick_a_cause:
    assert property (timer_a_osc_tick |-> $past(osc_comparator, 3))
      else $error("tick a without rise");
  a_tick_b_cause:
    assert property (timer_b_osc_tick |-> $past(osc_comparator, 3))
      else $error("tick b without rise");
  a_no_tick_off:
    assert property (s_osc_off |-> !timer_a_osc_tick && !timer_b_osc_tick)
      else $error("tick while off");
endmodule
bind cso_ctrl cso_ctrl_chk #(.LARGE_PACKAGE(LARGE_PACKAGE)) i_cso_ctrl_chk (.*);

// ---- verif/cso_pad_model.sv ----
// Purpose: Touch pad and comparator seen by cso_ctrl
// Assumes: Bench sets pad state and half period
// Notes:   Comparator idles low when the pad is not swinging
`timescale 1ns/1ps
module cso_pad_model (
  // Clock
  input  wire logic       ref_clk,
  // Oscillator power and pad state
  input  wire logic       osc_enable,
  input  wire logic       pin_current_enable,
  input  wire logic       pin_ready,
  input  wire logic       noise_on,
  input  wire logic [7:0] half_cycles,
  // Comparator and rising edge tally
  output logic            osc_comparator,
  output int              rise_count
);
  logic [7:0] phase_reg = 8'h00;
  logic       run;
  // Swings on pin current or on noise, stalls if the pin is not set up
  assign run = pin_ready && ((osc_enable && pin_current_enable) || noise_on);
  initial osc_comparator = 1'b0;
  initial rise_count = 0;
  always @(posedge ref_clk) begin
    if (!run) begin
      osc_comparator <= 1'b0;
      phase_reg      <= 8'h00;
    end else if (phase_reg == half_cycles - 8'h01) begin
      osc_comparator <= !osc_comparator;
      rise_count     <= rise_count + int'(!osc_comparator);
      phase_reg      <= 8'h00;
    end else begin
      phase_reg <= phase_reg + 8'h01;
    end
  end
endmodule

// ---- verif/cso_ctrl_tb.sv ----
// Purpose: Self-checking bench for cso_ctrl
// Assumes: Pad model on the comparator; a four-channel copy checks the small variant
// Notes:   A fixed software loop is the time base
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module cso_ctrl_tb;
  import cso_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, sense_pin_select, half_cycles = 8'h0a;
  logic osc_comparator, osc_enable, pin_current_enable, ref_variable_select;
  logic [1:0] current_range_out;
  logic timer_b_gate_pin = 1'b0, timer_a_osc_tick, timer_b_osc_tick;
  logic pin_ready = 1'b0, noise_on = 1'b0;
  logic [7:0] small_pin_select;
  int   rise_count, failures = 0, n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  cso_ctrl #(.LARGE_PACKAGE(1'b1)) i_cso_ctrl (.*);
  cso_pad_model i_cso_pad_model (.*);
  // Four-channel variant shares the stimulus; only its pin select is watched
  cso_ctrl #(.LARGE_PACKAGE(1'b0)) i_cso_ctrl_small (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (),
    .osc_comparator      (osc_comparator),
    .osc_enable          (),
    .pin_current_enable  (),
    .ref_variable_select (),
    .current_range_out   (),
    .sense_pin_select    (small_pin_select),
    .timer_b_gate_pin    (timer_b_gate_pin),
    .timer_a_osc_tick    (),
    .timer_b_osc_tick    ()
  );
  // ----------------------------------------
  // Bus and pad helpers
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    `CHECK(reg_rdata, e)
  endtask
  task automatic wait_cmp(input logic lvl);
    int k;
    for (k = 0; k < 500 && osc_comparator !== lvl; k++) @(negedge ref_clk);
    if (k == 500) begin
      failures++;
      print_verdict();
    end
  endtask
  // Swing for a fixed time, then stop while low and let ticks drain
  task automatic run_pad(output int rises, output int ta_n, output int tb_n);
    int r0;
    r0 = rise_count;
    ta_n = 0;
    tb_n = 0;
    pin_ready <= 1'b1;
    for (int k = 0; k < 260; k++) begin
      @(negedge ref_clk);
      // An unknown tick counts as a tick, so it cannot hide in a zero count
      ta_n += int'(timer_a_osc_tick !== 1'b0);
      tb_n += int'(timer_b_osc_tick !== 1'b0);
      if (k >= 200 && osc_comparator === 1'b0) pin_ready <= 1'b0;
    end
    rises = rise_count - r0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd_chk(3'(i), 8'h00);
    `CHECK({osc_enable, pin_current_enable, sense_pin_select}, 10'h000)
    $display("test reset done");
  endtask
  task automatic t_control;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[2], 2'h0, i[1:0], 2'h0};
      wr(OFF_SENSE_CONTROL_A, d);
      repeat (3) @(negedge ref_clk);
      `CHECK({osc_enable, current_range_out}, {1'(i != 0), i[1:0]})
      `CHECK(pin_current_enable, 1'(i[1:0] != 0))
      `CHECK(ref_variable_select, i[2])
      rd_chk(OFF_SENSE_CONTROL_A, d);
    end
    wr(OFF_SENSE_CONTROL_A, 8'h7f);
    repeat (3) @(negedge ref_clk);
    `CHECK(osc_enable, 1'b0)
    rd_chk(OFF_SENSE_CONTROL_A, 8'h4d);
    // A write while frozen is lost
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(OFF_SENSE_CONTROL_A, 8'h00);
    ce <= 1'b1;
    rd_chk(OFF_SENSE_CONTROL_A, 8'h4d);
    $display("test control done");
  endtask
  task automatic t_channels;
    wr(OFF_SENSE_CONTROL_A, 8'h84);
    for (int ch = 0; ch < 16; ch++) begin
      wr(OFF_SENSE_CONTROL_B, 8'(ch));
      repeat (3) @(negedge ref_clk);
      `CHECK(sense_pin_select, (ch < 8) ? 8'h01 << ch : 8'h00)
      `CHECK(small_pin_select, (ch < 4) ? 8'h01 << ch : 8'h00)
      rd_chk(OFF_SENSE_CONTROL_B, 8'(ch));
    end
    wr(OFF_SENSE_CONTROL_B, 8'h05);
    wr(OFF_SENSE_CONTROL_A, 8'h04);
    repeat (3) @(negedge ref_clk);
    `CHECK(sense_pin_select, 8'h00)
    wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
    $display("test channels done");
  endtask
  task automatic t_direction;
    wr(OFF_SENSE_CONTROL_A, 8'h8c);
    pin_ready <= 1'b1;
    wait_cmp(1'b1);
    repeat (4) @(negedge ref_clk);
    rd_chk(OFF_SENSE_CONTROL_A, 8'h8e);
    wait_cmp(1'b0);
    repeat (4) @(negedge ref_clk);
    pin_ready <= 1'b0;
    rd_chk(OFF_SENSE_CONTROL_A, 8'h8c);
    $display("test direction done");
  endtask
  task automatic t_timer_b;
    logic [7:0] ctl [5] = '{8'hc1, 8'hc3, 8'hc3, 8'hc0, 8'h81};
    logic g [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic cnt [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int rises, ta_n, tb_n;
    logic [15:0] e;
    for (int i = 0; i < 5; i++) begin
      wr(OFF_TIMER_B_CONTROL, ctl[i]);
      timer_b_gate_pin <= g[i]; // gate window held by the bench
      wr(OFF_TIMER_B_COUNT_L, 8'h00);
      run_pad(rises, ta_n, tb_n);
      `CHECK(tb_n, (ctl[i][7:6] == TB_SRC_SENSE_OSC) ? rises : 0)
      `CHECK(ta_n, 0)
      e = cnt[i] ? 16'(rises) : 16'h0000;
      rd_chk(OFF_TIMER_B_COUNT_L, e[7:0]);
      rd_chk(OFF_TIMER_B_COUNT_H, e[15:8]);
    end
    $display("test timer b done");
  endtask
  task automatic t_timer_a;
    logic [7:0] a [6] = '{8'h8d, 8'h8d, 8'h8c, 8'h81, 8'hc1, 8'h01};
    logic cfg [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic nz [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic go [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    int rises, ta_n, tb_n;
    half_cycles <= 8'h03;
    for (int i = 0; i < 6; i++) begin
      wr(OFF_SENSE_CONTROL_A, a[i]);
      wr(OFF_TIMER_A_CONFIG, {7'h00, cfg[i]});
      noise_on <= nz[i];
      repeat (3) @(negedge ref_clk);
      run_pad(rises, ta_n, tb_n);
      `CHECK(ta_n, go[i] ? rises : 0)
      `CHECK(tb_n, 0)
    end
    $display("test timer a done");
  endtask
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_control();
    t_channels();
    t_direction();
    t_timer_b();
    t_timer_a();
    print_verdict();
  end
endmodule
